// ===== rtl/ascan_receiver_processing.sv
// Pulser control, receive filter, rectify, reject, peak memory and peak hold.
// Assumes samples arrive synchronous to sys_clk, one record per transmit pulse.
`timescale 1ns/1ps
module ascan_receiver_processing #(
	parameter int PRF_CYCLES = ascan_pkg::PRF_CYC,
	parameter int REC_LEN = ascan_pkg::REC_LEN
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	output logic txPulse,
	output logic txOnTr,
	output logic txOnAux,
	output logic [2:0] filterSel,
	input wire logic sampleValid,
	input wire logic signed [ascan_pkg::SAMPLE_W-1:0] sampleIn,
	output logic liveValid,
	output logic [$clog2(REC_LEN)-1:0] liveIdx,
	output logic signed [ascan_pkg::AMP_W-1:0] liveOut,
	output logic signed [ascan_pkg::AMP_W-1:0] envOut,
	output logic signed [ascan_pkg::AMP_W-1:0] holdOut,
	output logic [7:0] rejectLevel,
	output logic rejectDual,
	output logic peakMemFlag,
	output logic peakHoldFlag
);
	localparam int IW = $clog2(REC_LEN);
	localparam int AW = ascan_pkg::AMP_W;
	localparam int SW = ascan_pkg::SAMPLE_W;

	// Register state
	ascan_pkg::test_mode_t mode_reg, mode_next;
	ascan_pkg::rect_t rect_reg, rect_next;
	logic [2:0] filt_reg, filt_next;
	logic wave_reg, wave_next;
	logic conn_reg, conn_next;
	logic [3:0] freq_reg, freq_next;
	logic dac_reg, dac_next;
	logic [6:0] rej_reg, rej_next;
	logic [23:0] transit_reg, transit_next;
	logic [31:0] rd_reg, rd_next;
	logic pm_reg, pm_next;
	logic second_reg, second_next;
	ascan_pkg::hold_state_t hold_reg, hold_next;
	// Acquisition and pipeline state
	logic acq_reg, acq_next;
	logic [IW-1:0] idx_reg, idx_next;
	logic signed [SW-1:0] prev_reg, prev_next;
	logic s1Valid_reg, s1Valid_next;
	logic s1Last_reg, s1Last_next;
	logic [IW-1:0] s1Idx_reg, s1Idx_next;
	logic signed [AW-1:0] s1Filt_reg, s1Filt_next;
	logic liveValid_reg, liveValid_next;
	logic [IW-1:0] liveIdx_reg, liveIdx_next;
	logic signed [AW-1:0] live_reg, live_next;

	logic ctrlWr, keyWr, fire, pmToggle, holdPress, rfBlocked, pmClear, holdWe, envWe;
	logic [1:0] wrMode, wrRect;
	logic signed [AW-1:0] rectVal, rejVal, magVal;
	logic [17:0] rejProd;

	// Strobe decode
	assign ctrlWr = regWr && regAddr == ascan_pkg::OFS_CTRL;
	assign keyWr = regWr && regAddr == ascan_pkg::OFS_KEY;
	assign wrMode = regWrData[ascan_pkg::CTRL_MODE_LSB +: 2];
	assign wrRect = regWrData[ascan_pkg::CTRL_RECT_LSB +: 2];
	assign rfBlocked = pm_reg || regWrData[ascan_pkg::CTRL_DAC_BIT];
	assign pmToggle = keyWr && regWrData[ascan_pkg::KEY_PEAKMEM_BIT] && (pm_reg || rect_reg != ascan_pkg::RECT_RF);
	assign holdPress = keyWr && regWrData[ascan_pkg::KEY_HOLD_BIT] && second_reg;
	assign pmClear = pmToggle && !pm_reg;

	// Register file next values and read mux
	always_comb begin
		mode_next = mode_reg;
		rect_next = rect_reg;
		filt_next = filt_reg;
		wave_next = wave_reg;
		conn_next = conn_reg;
		freq_next = freq_reg;
		dac_next = dac_reg;
		rej_next = rej_reg;
		transit_next = transit_reg;
		pm_next = pmToggle ? !pm_reg : pm_reg;
		second_next = second_reg;
		if (ctrlWr) begin
			if (wrMode != 2'h3) begin
				mode_next = ascan_pkg::test_mode_t'(wrMode);
			end
			if (ascan_pkg::rect_t'(wrRect) == ascan_pkg::RECT_RF && rfBlocked) begin
				rect_next = (rect_reg == ascan_pkg::RECT_RF) ? ascan_pkg::RECT_FULL : rect_reg;
			end else begin
				rect_next = ascan_pkg::rect_t'(wrRect);
			end
			filt_next = regWrData[ascan_pkg::CTRL_FILT_LSB +: 3];
			wave_next = regWrData[ascan_pkg::CTRL_WAVE_BIT];
			conn_next = regWrData[ascan_pkg::CTRL_CONN_BIT];
			freq_next = regWrData[ascan_pkg::CTRL_FREQ_LSB +: 4];
			dac_next = regWrData[ascan_pkg::CTRL_DAC_BIT];
		end
		if (regWr && regAddr == ascan_pkg::OFS_REJECT) begin
			rej_next = (regWrData[6:0] > ascan_pkg::REJ_MAX_PCT || regWrData[31:7] != 25'h0) ?
				ascan_pkg::REJ_MAX_PCT : regWrData[6:0];
		end
		if (regWr && regAddr == ascan_pkg::OFS_TRANSIT) begin
			transit_next = regWrData[23:0];
		end
		// A second-function press arms the next key only
		if (keyWr) begin
			second_next = regWrData[ascan_pkg::KEY_SECOND_BIT];
		end
		rd_next = 32'h0;
		if (regRd) begin
			case (regAddr)
				ascan_pkg::OFS_CTRL: rd_next = {17'h0, dac_reg, rect_reg, 1'b0, filt_reg, freq_reg,
					conn_reg, wave_reg, mode_reg};
				ascan_pkg::OFS_REJECT: rd_next = {25'h0, rej_reg};
				ascan_pkg::OFS_STATUS: rd_next = {27'h0, acq_reg, second_reg, hold_reg == ascan_pkg::HOLD_FROZEN,
					hold_reg != ascan_pkg::HOLD_OFF, pm_reg};
				ascan_pkg::OFS_TRANSIT: rd_next = {8'h0, transit_reg};
				ascan_pkg::OFS_THICK: rd_next = (mode_reg == ascan_pkg::MODE_THROUGH) ?
					{8'h0, transit_reg} : {9'h0, transit_reg[23:1]};
				default: rd_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_reg <= ascan_pkg::test_mode_t'(ascan_pkg::CTRL_RST[ascan_pkg::CTRL_MODE_LSB +: 2]);
			rect_reg <= ascan_pkg::rect_t'(ascan_pkg::CTRL_RST[ascan_pkg::CTRL_RECT_LSB +: 2]);
			filt_reg <= ascan_pkg::CTRL_RST[ascan_pkg::CTRL_FILT_LSB +: 3];
			wave_reg <= ascan_pkg::CTRL_RST[ascan_pkg::CTRL_WAVE_BIT];
			conn_reg <= ascan_pkg::CTRL_RST[ascan_pkg::CTRL_CONN_BIT];
			freq_reg <= ascan_pkg::CTRL_RST[ascan_pkg::CTRL_FREQ_LSB +: 4];
			dac_reg <= ascan_pkg::CTRL_RST[ascan_pkg::CTRL_DAC_BIT];
			rej_reg <= ascan_pkg::REJ_RST;
			transit_reg <= 24'h0;
			rd_reg <= 32'h0;
			pm_reg <= 1'b0;
			second_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			rect_reg <= rect_next;
			filt_reg <= filt_next;
			wave_reg <= wave_next;
			conn_reg <= conn_next;
			freq_reg <= freq_next;
			dac_reg <= dac_next;
			rej_reg <= rej_next;
			transit_reg <= transit_next;
			rd_reg <= rd_next;
			pm_reg <= pm_next;
			second_reg <= second_next;
		end
	end

	// Divider and pulse width timer
	pulser_gen #(
		.PRF_CYCLES(PRF_CYCLES)
	) u_pulser (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.squareMode(wave_reg),
		.freqSel(freq_reg),
		.fire(fire),
		.txPulse(txPulse)
	);

	// Connector steering; pulse-echo alone may use the auxiliary connector
	assign txOnAux = txPulse && mode_reg == ascan_pkg::MODE_PULSE_ECHO && conn_reg;
	assign txOnTr = txPulse && !txOnAux;

	// Rectify then reject on the filtered sample; the level is linear in percent
	assign rejProd = {11'h0, rej_reg} * {7'h0, ascan_pkg::REJ_SCALE};
	assign rejectLevel = rejProd[ascan_pkg::REJ_SHIFT +: 8];
	assign rejectDual = rect_reg == ascan_pkg::RECT_RF;
	always_comb begin
		case (rect_reg)
			ascan_pkg::RECT_FULL: rectVal = (s1Filt_reg < 0) ? -s1Filt_reg : s1Filt_reg;
			ascan_pkg::RECT_POS: rectVal = (s1Filt_reg < 0) ? '0 : s1Filt_reg;
			ascan_pkg::RECT_NEG: rectVal = (s1Filt_reg < 0) ? -s1Filt_reg : '0;
			default: rectVal = s1Filt_reg;
		endcase
		magVal = (rectVal < 0) ? -rectVal : rectVal;
		rejVal = (magVal < $signed({2'b00, rejectLevel})) ? '0 : rectVal;
	end

	// Acquisition, filter stage and live output stage
	always_comb begin
		acq_next = acq_reg;
		idx_next = idx_reg;
		prev_next = prev_reg;
		s1Valid_next = 1'b0;
		s1Last_next = 1'b0;
		s1Idx_next = idx_reg;
		s1Filt_next = s1Filt_reg;
		if (fire) begin
			acq_next = 1'b1;
			idx_next = '0;
			prev_next = '0;
		end else if (acq_reg && sampleValid) begin
			s1Valid_next = 1'b1;
			s1Last_next = idx_reg == IW'(REC_LEN - 1);
			prev_next = sampleIn;
			idx_next = idx_reg + 1'b1;
			acq_next = idx_reg != IW'(REC_LEN - 1);
			// Simple low or high emphasis for five bands, the other three pass straight; the first stage of the chain
			case (ascan_pkg::band_t'(filt_reg))
				ascan_pkg::BAND_DC_10, ascan_pkg::BAND_02_1, ascan_pkg::BAND_05_4:
					s1Filt_next = AW'((AW'(sampleIn) + AW'(prev_reg)) >>> 1);
				ascan_pkg::BAND_5_15, ascan_pkg::BAND_8_26:
					s1Filt_next = AW'(AW'(sampleIn) - (AW'(prev_reg) >>> 1));
				default: s1Filt_next = AW'(sampleIn);
			endcase
		end
		liveValid_next = s1Valid_reg;
		liveIdx_next = s1Valid_reg ? s1Idx_reg : liveIdx_reg;
		live_next = s1Valid_reg ? rejVal : live_reg;
	end

	// Hold sequencing: armed waits for a record start so the capture is whole
	always_comb begin
		hold_next = hold_reg;
		case (hold_reg)
			ascan_pkg::HOLD_OFF: if (holdPress) hold_next = ascan_pkg::HOLD_ARMED;
			ascan_pkg::HOLD_ARMED: begin
				if (holdPress) hold_next = ascan_pkg::HOLD_OFF;
				else if (fire) hold_next = ascan_pkg::HOLD_CAPTURE;
			end
			ascan_pkg::HOLD_CAPTURE: begin
				if (holdPress) hold_next = ascan_pkg::HOLD_OFF;
				else if (s1Valid_reg && s1Last_reg) hold_next = ascan_pkg::HOLD_FROZEN;
			end
			ascan_pkg::HOLD_FROZEN: if (holdPress) hold_next = ascan_pkg::HOLD_OFF;
			default: hold_next = ascan_pkg::HOLD_OFF;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			acq_reg <= 1'b0;
			idx_reg <= '0;
			prev_reg <= '0;
			s1Valid_reg <= 1'b0;
			s1Last_reg <= 1'b0;
			s1Idx_reg <= '0;
			s1Filt_reg <= '0;
			liveValid_reg <= 1'b0;
			liveIdx_reg <= '0;
			live_reg <= '0;
			hold_reg <= ascan_pkg::HOLD_OFF;
		end else begin
			acq_reg <= acq_next;
			idx_reg <= idx_next;
			prev_reg <= prev_next;
			s1Valid_reg <= s1Valid_next;
			s1Last_reg <= s1Last_next;
			s1Idx_reg <= s1Idx_next;
			s1Filt_reg <= s1Filt_next;
			liveValid_reg <= liveValid_next;
			liveIdx_reg <= liveIdx_next;
			live_reg <= live_next;
			hold_reg <= hold_next;
		end
	end

	// Peak stages take the rejected sample in the same cycle as the live register
	assign envWe = s1Valid_reg && pm_reg;
	assign holdWe = s1Valid_reg && hold_reg == ascan_pkg::HOLD_CAPTURE;

	envelope_mem #(.DEPTH(REC_LEN), .WIDTH(AW)) u_env (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.clear(pmClear),
		.we(envWe),
		.maxMode(1'b1),
		.wIdx(s1Idx_reg),
		.wData(rejVal),
		.rIdx(s1Idx_reg),
		.rData(envOut)
	);

	envelope_mem #(.DEPTH(REC_LEN), .WIDTH(AW)) u_hold (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.clear(1'b0),
		.we(holdWe),
		.maxMode(1'b0),
		.wIdx(s1Idx_reg),
		.wData(rejVal),
		.rIdx(s1Idx_reg),
		.rData(holdOut)
	);

	assign regRdData = rd_reg;
	assign filterSel = filt_reg;
	assign liveValid = liveValid_reg;
	assign liveIdx = liveIdx_reg;
	assign liveOut = live_reg;
	assign peakMemFlag = pm_reg;
	assign peakHoldFlag = hold_reg != ascan_pkg::HOLD_OFF;

	// Checks
	property p_rf_block;
		@(posedge sys_clk) disable iff (!rst_b) (pm_reg || dac_reg) |-> rect_reg != ascan_pkg::RECT_RF;
	endproperty
	a_rf_block: assert property (p_rf_block) else $error("RF active with peak memory or DAC");
	property p_thick_full;
		@(posedge sys_clk) disable iff (!rst_b)
		regRd && regAddr == ascan_pkg::OFS_THICK && mode_reg == ascan_pkg::MODE_THROUGH |=> regRdData == {8'h0, transit_reg};
	endproperty
	a_thick_full: assert property (p_thick_full) else $error("Through mode thickness halved");
	property p_thick_half;
		@(posedge sys_clk) disable iff (!rst_b)
		regRd && regAddr == ascan_pkg::OFS_THICK && mode_reg != ascan_pkg::MODE_THROUGH |=>
			regRdData == {9'h0, $past(transit_reg[23:1])};
	endproperty
	a_thick_half: assert property (p_thick_half) else $error("Echo mode thickness not halved");
	property p_spike;
		@(posedge sys_clk) disable iff (!rst_b) fire && !wave_reg |=> txPulse ##1 !txPulse;
	endproperty
	a_spike: assert property (p_spike) else $error("Spike width wrong");
	property p_aux_only_pe;
		@(posedge sys_clk) disable iff (!rst_b) txOnAux |-> mode_reg == ascan_pkg::MODE_PULSE_ECHO && !txOnTr;
	endproperty
	a_aux_only_pe: assert property (p_aux_only_pe) else $error("Aux connector driven outside pulse-echo");
	property p_reject_low;
		@(posedge sys_clk) disable iff (!rst_b) s1Valid_reg && magVal < $signed({2'b00, rejectLevel}) |=> liveOut == 0;
	endproperty
	a_reject_low: assert property (p_reject_low) else $error("Sample below reject shown");
	property p_reject_pass;
		@(posedge sys_clk) disable iff (!rst_b)
		s1Valid_reg && magVal >= $signed({2'b00, rejectLevel}) |=> liveOut == $past(rectVal);
	endproperty
	a_reject_pass: assert property (p_reject_pass) else $error("Sample above reject altered");
	property p_pm_toggle;
		@(posedge sys_clk) disable iff (!rst_b)
		keyWr && regWrData[ascan_pkg::KEY_PEAKMEM_BIT] && rect_reg != ascan_pkg::RECT_RF |=> pm_reg != $past(pm_reg);
	endproperty
	a_pm_toggle: assert property (p_pm_toggle) else $error("Peak memory key did not toggle");
	property p_pm_refuse;
		@(posedge sys_clk) disable iff (!rst_b) !pm_reg && rect_reg == ascan_pkg::RECT_RF |=> !pm_reg;
	endproperty
	a_pm_refuse: assert property (p_pm_refuse) else $error("Peak memory enabled in RF");
	property p_hold_frozen;
		@(posedge sys_clk) disable iff (!rst_b) holdWe |-> hold_reg == ascan_pkg::HOLD_CAPTURE && peakHoldFlag;
	endproperty
	a_hold_frozen: assert property (p_hold_frozen) else $error("Hold store written outside capture");
	property p_hold_toggle;
		@(posedge sys_clk) disable iff (!rst_b) holdPress |=> peakHoldFlag != $past(peakHoldFlag);
	endproperty
	a_hold_toggle: assert property (p_hold_toggle) else $error("Hold key did not toggle");

	c_pm_on: cover property (@(posedge sys_clk) disable iff (!rst_b) pmClear ##1 envWe);
	c_hold_frozen: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(hold_reg == ascan_pkg::HOLD_FROZEN));
	c_rf_reject: cover property (@(posedge sys_clk) disable iff (!rst_b) s1Valid_reg && rejectDual && rejVal < 0);
	c_square: cover property (@(posedge sys_clk) disable iff (!rst_b) fire && wave_reg);
endmodule : ascan_receiver_processing

// ===== rtl/ascan_pkg.sv
// Shared constants for the A-scan receive processing block.
// Assumes a single 100 MHz system clock; all other rates come from counters.
package ascan_pkg;
	// Clock and timing
	localparam int CLK_MHZ = 100;
	localparam int SPIKE_NS = 10;
	localparam int SPIKE_CYC = (SPIKE_NS * CLK_MHZ + 999) / 1000;
	localparam int SQUARE_STEP_NS = 20;
	localparam int SQUARE_STEP_CYC = (SQUARE_STEP_NS * CLK_MHZ + 999) / 1000;
	localparam int PRF_HZ = 1000;
	localparam int PRF_CYC = (CLK_MHZ * 1000000) / PRF_HZ;

	// Record and sample widths
	localparam int REC_LEN = 64;
	localparam int SAMPLE_W = 8;
	localparam int AMP_W = 10;

	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_REJECT = 8'h04;
	localparam logic [7:0] OFS_KEY = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_TRANSIT = 8'h10;
	localparam logic [7:0] OFS_THICK = 8'h14;

	// Control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_WAVE_BIT = 2;
	localparam int CTRL_CONN_BIT = 3;
	localparam int CTRL_FREQ_LSB = 4;
	localparam int CTRL_FILT_LSB = 8;
	localparam int CTRL_RECT_LSB = 12;
	localparam int CTRL_DAC_BIT = 14;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;

	// Key register bits (write one to press)
	localparam int KEY_PEAKMEM_BIT = 0;
	localparam int KEY_SECOND_BIT = 1;
	localparam int KEY_HOLD_BIT = 2;

	// Status register bits
	localparam int ST_PEAKMEM_BIT = 0;
	localparam int ST_HOLD_BIT = 1;
	localparam int ST_CAPT_BIT = 2;
	localparam int ST_SECOND_BIT = 3;
	localparam int ST_ACQ_BIT = 4;

	// Reject: percent of full_screen_height, linear
	localparam int FULL_SCREEN_HEIGHT = 128;
	localparam logic [6:0] REJ_MAX_PCT = 7'h50;
	localparam logic [6:0] REJ_RST = 7'h00;
	localparam int REJ_SHIFT = 10;
	localparam logic [10:0] REJ_SCALE = 11'((FULL_SCREEN_HEIGHT * 1024 + 99) / 100);

	typedef enum logic [1:0] {
		MODE_PULSE_ECHO = 2'h0,
		MODE_PITCH_CATCH = 2'h1,
		MODE_THROUGH = 2'h2
	} test_mode_t;

	typedef enum logic [1:0] {
		RECT_FULL = 2'h0,
		RECT_POS = 2'h1,
		RECT_NEG = 2'h2,
		RECT_RF = 2'h3
	} rect_t;

	typedef enum logic [2:0] {
		BAND_2_21 = 3'h0,
		BAND_02_10 = 3'h1,
		BAND_02_1 = 3'h2,
		BAND_05_4 = 3'h3,
		BAND_15_8 = 3'h4,
		BAND_5_15 = 3'h5,
		BAND_8_26 = 3'h6,
		BAND_DC_10 = 3'h7
	} band_t;

	typedef enum logic [3:0] {
		HOLD_OFF = 4'h1,
		HOLD_ARMED = 4'h2,
		HOLD_CAPTURE = 4'h4,
		HOLD_FROZEN = 4'h8
	} hold_state_t;
endpackage : ascan_pkg

// ===== rtl/pulser_gen.sv
// Pulse repetition divider and excitation pulse width timer.
// Assumes width selections are stable around the fire strobe.
`timescale 1ns/1ps
module pulser_gen #(
	parameter int PRF_CYCLES = ascan_pkg::PRF_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic squareMode,
	input wire logic [3:0] freqSel,
	output logic fire,
	output logic txPulse
);
	logic [31:0] prfCnt_reg, prfCnt_next;
	logic [7:0] width_reg, width_next;
	logic tx_reg, tx_next;

	// Spike width is fixed; only square mode listens to the frequency selection
	always_comb begin
		prfCnt_next = prfCnt_reg - 32'h1;
		width_next = width_reg;
		tx_next = tx_reg;
		fire = 1'b0;
		if (prfCnt_reg == 32'h0) begin
			prfCnt_next = 32'(PRF_CYCLES - 1);
			fire = 1'b1;
			tx_next = 1'b1;
			if (squareMode) begin
				width_next = 8'(({4'h0, freqSel} + 8'h1) * 8'(ascan_pkg::SQUARE_STEP_CYC)) - 8'h1;
			end else begin
				width_next = 8'(ascan_pkg::SPIKE_CYC - 1);
			end
		end else if (width_reg != 8'h0) begin
			width_next = width_reg - 8'h1;
		end else begin
			tx_next = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			prfCnt_reg <= 32'h0;
			width_reg <= 8'h0;
			tx_reg <= 1'b0;
		end else begin
			prfCnt_reg <= prfCnt_next;
			width_reg <= width_next;
			tx_reg <= tx_next;
		end
	end

	assign txPulse = tx_reg;
endmodule : pulser_gen

// ===== rtl/envelope_mem.sv
// One waveform record of flip-flop storage, per sample index.
// Max mode keeps the larger value; otherwise a write overwrites.
`timescale 1ns/1ps
module envelope_mem #(
	parameter int DEPTH = ascan_pkg::REC_LEN,
	parameter int WIDTH = ascan_pkg::AMP_W
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clear,
	input wire logic we,
	input wire logic maxMode,
	input wire logic [$clog2(DEPTH)-1:0] wIdx,
	input wire logic signed [WIDTH-1:0] wData,
	input wire logic [$clog2(DEPTH)-1:0] rIdx,
	output logic signed [WIDTH-1:0] rData
);
	logic signed [WIDTH-1:0] mem_reg [DEPTH];
	logic signed [WIDTH-1:0] mem_next [DEPTH];
	logic signed [WIDTH-1:0] rd_reg, rd_next;

	// Clear beats write so a fresh envelope starts from zero
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_next[i] = clear ? '0 : mem_reg[i];
		end
		if (!clear && we && (!maxMode || wData > mem_reg[wIdx])) begin
			mem_next[wIdx] = wData;
		end
		rd_next = mem_reg[rIdx];
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
			rd_reg <= '0;
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= mem_next[i];
			end
			rd_reg <= rd_next;
		end
	end

	assign rData = rd_reg;
endmodule : envelope_mem

// ===== tb/frontend_model.sv
// Front end model: one echo record per transmit pulse.
// Assumes txPulse from the block; slow halves the sample rate.
`timescale 1ns/1ps
module frontend_model (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic txPulse,
	input wire logic slow,
	input wire logic [6:0] amp,
	output logic sampleValid,
	output logic signed [7:0] sampleIn
);
	logic txSeen;
	logic gap;
	logic [6:0] cnt;
	// Idle data inverts each cycle so a stale sample never looks valid
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			{txSeen, gap, cnt, sampleValid} <= '0;
			sampleIn <= 8'sh00;
		end else begin
			txSeen <= txPulse;
			gap <= slow & ~gap;
			sampleValid <= 1'b0;
			sampleIn <= ~sampleIn;
			if (txPulse && !txSeen) begin
				cnt <= 7'h40;
			end else if (cnt != 7'h00 && !gap) begin
				sampleValid <= 1'b1;
				sampleIn <= cnt[0] ? -$signed({1'b0, amp ^ cnt}) : $signed({1'b0, amp ^ cnt});
				cnt <= cnt - 7'h01;
			end
		end
	end
endmodule : frontend_model

// ===== tb/ascan_receiver_processing_tb_top.sv
// Self-checking bench for the A-scan receive processing block.
// Assumes the front end model and a pulse period cut to 200 cycles.
`timescale 1ns/1ps
module ascan_receiver_processing_tb_top;
	logic sys_clk, rst_b, regWr, regRd, sampleValid, txPulse, txOnTr, txOnAux, rejectDual, auxSeen, trSeen;
	logic peakMemFlag, peakHoldFlag, liveValid, slow, rdPend, rejOn, posOn, negOn, envOn, holdOn, holdCap;
	logic [7:0] regAddr, rejectLevel;
	logic [31:0] regWrData, regRdData;
	logic [2:0] filterSel;
	logic [5:0] liveIdx;
	logic [6:0] amp;
	logic [3:0] fq;
	logic signed [7:0] sampleIn;
	logic signed [9:0] liveOut, envOut, holdOut, mag;
	logic signed [9:0] envRef [64];
	logic signed [9:0] holdRef [64];
	logic [63:0] envSeen = '0;
	logic [63:0] holdSeen = '0;
	logic [31:0] expQ [$];
	logic [3:0] cfg [5] = '{4'h9, 4'hE, 4'hC, 4'h0, 4'h4};
	int seed, w, i, pct;
	int badCount = 0;
	int checked = 0;

	// Free-running system clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	ascan_receiver_processing #(.PRF_CYCLES(200), .REC_LEN(64)) i_ascan_receiver_processing (
		.sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .txPulse(txPulse), .txOnTr(txOnTr), .txOnAux(txOnAux),
		.filterSel(filterSel), .sampleValid(sampleValid), .sampleIn(sampleIn), .liveValid(liveValid),
		.liveIdx(liveIdx), .liveOut(liveOut), .envOut(envOut), .holdOut(holdOut), .rejectLevel(rejectLevel),
		.rejectDual(rejectDual), .peakMemFlag(peakMemFlag), .peakHoldFlag(peakHoldFlag));
	frontend_model i_frontend_model (.sys_clk(sys_clk), .rst_b(rst_b), .txPulse(txPulse), .slow(slow),
		.amp(amp), .sampleValid(sampleValid), .sampleIn(sampleIn));

	task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			badCount++;
			$display("Error %0t: read %h, expected %h", $time, got, exp);
		end
	endtask : chkReg
	task automatic chkPort(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			badCount++;
			$display("Error %0t: port %h, expected %h", $time, got, exp);
		end
	endtask : chkPort
	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", checked, badCount);
		if (badCount == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		{regWr, regAddr, regWrData} <= {1'b1, a, d};
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		{regRd, regAddr} <= {1'b1, a};
		expQ.push_back(e);
		@(posedge sys_clk);
		regRd <= 1'b0;
	endtask : rd
	// Waits out any pulse in flight, then measures the next; bounded so a dead pulser ends the run
	task automatic pulse(output int w);
		int n = 0;
		w = 0;
		@(posedge sys_clk);
		amp <= 7'($random(seed));
		while (txPulse !== 1'b0 && n < 700) begin
			@(negedge sys_clk);
			n++;
		end
		while (txPulse !== 1'b1 && n < 700) begin
			@(negedge sys_clk);
			n++;
		end
		{auxSeen, trSeen} = {txOnAux, txOnTr};
		while (txPulse === 1'b1 && n < 700) begin
			@(negedge sys_clk);
			w++;
			n++;
		end
		if (n >= 700) begin
			badCount++;
			tally_and_finish();
		end
	endtask : pulse
	// Leaves the caller between records, when acquisition is idle
	task automatic quiet;
		pulse(w);
		repeat (80) @(posedge sys_clk);
	endtask : quiet

	// Read data is compared in the one cycle it stands; live stream checked on each valid
	always @(posedge sys_clk) begin
		rdPend <= regRd;
		if (rdPend === 1'b1 && expQ.size() > 0)
			chkReg(regRdData, expQ.pop_front());
		if (liveValid === 1'b1) begin
			mag = liveOut < 0 ? -liveOut : liveOut;
			if (rejOn) chkPort(32'(mag == 0 || mag >= 10'(rejectLevel)), 1);
			if (posOn) chkPort(32'(liveOut >= 0 && (liveIdx[0] == negOn || liveOut == 0)), 1);
			if (envOn && envSeen[liveIdx]) chkPort(32'(envOut >= envRef[liveIdx]), 1);
			else if (envOn) chkPort(envOut, 0);
			if (holdOn && holdSeen[liveIdx]) chkPort(holdOut, holdRef[liveIdx]);
			// Envelope model keeps the running maximum; hold model keeps the captured record only
			if (envOn) envRef[liveIdx] = (envSeen[liveIdx] && envRef[liveIdx] > liveOut) ? envRef[liveIdx] : liveOut;
			if (holdCap) holdRef[liveIdx] = liveOut;
			envSeen[liveIdx] = envSeen[liveIdx] | envOn;
			holdSeen[liveIdx] = holdSeen[liveIdx] | holdCap;
		end
	end

	// Main sequence: registers, pulser, filter, reject, peak memory, peak hold
	initial begin
		seed = 3522;
		{rst_b, regWr, regRd, slow, rejOn, posOn, negOn, envOn, holdOn, holdCap, regAddr, regWrData, amp} = '0;
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h1C, 32'h0);
		for (i = 0; i < 4; i++) begin
			wr(8'h00, 32'(i));
			rd(8'h00, i == 3 ? 32'h2 : 32'(i));
		end
		// Mode 2 is still in force: thickness uses the full transit time
		wr(8'h10, 32'h0012345);
		rd(8'h14, 32'h0012345);
		wr(8'h00, 32'h0);
		rd(8'h14, 32'h00091A2);
		for (i = 0; i < 5; i++) begin
			fq = 4'($random(seed));
			wr(8'h00, {24'h0, fq, cfg[i]});
			pulse(w);
			pulse(w);
			chkPort(auxSeen, 32'(cfg[i][1:0] == 2'h0 && cfg[i][3]));
			chkPort(trSeen, 32'(!auxSeen));
			chkPort(w, cfg[i][2] ? 32'((fq + 1) * 2) : 32'h1);
		end
		for (i = 0; i < 8; i++) begin
			wr(8'h00, 32'(i) << 8);
			@(negedge sys_clk);
			chkPort(filterSel, 32'(i));
		end
		wr(8'h04, 32'h64);
		rd(8'h04, 32'h50);
		pct = {$random(seed)} % 81;
		wr(8'h04, 32'(pct));
		@(negedge sys_clk);
		chkPort(rejectLevel, 32'((pct * 1311) >> 10));
		wr(8'h00, 32'h1000);
		slow <= 1'b1;
		pulse(w);
		{rejOn, posOn} = 2'b11;
		repeat (3) pulse(w);
		// Slow records outlast quiet, so wait out the last one before switching polarity
		repeat (150) @(posedge sys_clk);
		wr(8'h00, 32'h2000);
		negOn = 1'b1;
		repeat (2) pulse(w);
		{rejOn, posOn, negOn, slow} = 4'h0;
		wr(8'h00, 32'h3000);
		@(negedge sys_clk);
		chkPort(rejectDual, 32'h1);
		wr(8'h00, 32'h7000);
		rd(8'h00, 32'h4000);
		wr(8'h00, 32'h3000);
		quiet();
		wr(8'h08, 32'h1);
		rd(8'h0C, 32'h0);
		wr(8'h00, 32'h0);
		quiet();
		wr(8'h08, 32'h1);
		@(negedge sys_clk);
		chkPort(peakMemFlag, 32'h1);
		envOn = 1'b1;
		repeat (3) pulse(w);
		quiet();
		envOn = 1'b0;
		wr(8'h00, 32'h3000);
		rd(8'h00, 32'h0);
		wr(8'h08, 32'h1);
		@(negedge sys_clk);
		chkPort(peakMemFlag, 32'h0);
		wr(8'h08, 32'h4);
		@(negedge sys_clk);
		chkPort(peakHoldFlag, 32'h0);
		wr(8'h08, 32'h2);
		wr(8'h08, 32'h4);
		@(negedge sys_clk);
		chkPort(peakHoldFlag, 32'h1);
		// The record after the press is the one captured
		holdCap = 1'b1;
		quiet();
		holdCap = 1'b0;
		quiet();
		rd(8'h0C, 32'h6);
		holdOn = 1'b1;
		repeat (3) pulse(w);
		quiet();
		holdOn = 1'b0;
		wr(8'h08, 32'h2);
		wr(8'h08, 32'h4);
		@(negedge sys_clk);
		chkPort(peakHoldFlag, 32'h0);
		repeat (3) @(posedge sys_clk);
		tally_and_finish();
	end
endmodule : ascan_receiver_processing_tb_top
